// ### core/bprx_pkg.sv
// Shared constants and types for the bit processor receive front end.
package bprx_pkg;

    localparam int MAX_PROC = 4;
    localparam int NUM_LAYERS = 12;
    localparam int SC_PER_RB = 12;
    localparam int RB_SAMPLES = NUM_LAYERS * SC_PER_RB;
    localparam int RB_WORDS = RB_SAMPLES / 2;
    localparam int RB_SPACING = 144;
    localparam int SYMBOL_GAP = 120;
    localparam int SYMBOLS_PER_FRAME = 140;

    // One constellation step of 256-QAM in 2.14 format.
    localparam logic signed [17:0] QAM_STEP = 18'sh004E9;
    localparam logic signed [17:0] QAM_B3 = QAM_STEP * 18'sh00002;
    localparam logic signed [17:0] QAM_B2 = QAM_STEP * 18'sh00004;
    localparam logic signed [17:0] QAM_B1 = QAM_STEP * 18'sh00008;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_HOST_SYM = 8'h04;
    localparam logic [7:0] REG_SCHED = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [7:0] HOST_SYM_RESET = 8'h00;

    localparam int CTRL_NPROC = 0;
    localparam int CTRL_UPLINK = 2;
    localparam int CTRL_ONE_LAYER = 3;
    localparam int CTRL_SKIP_NONE = 4;
    localparam int CTRL_LAYER = 8;
    localparam int SCHED_ENTRY = 0;
    localparam int SCHED_LAYER = 8;
    localparam int SCHED_SYM = 16;

    typedef enum logic [2:0] {
        MOD_NONE, MOD_BPSK, MOD_QPSK, MOD_QAM16, MOD_QAM64, MOD_QAM256
    } bprx_mod_type;

    typedef struct packed {
        logic signed [15:0] i;
        logic signed [15:0] q;
    } bprx_iq_type;

    typedef struct packed {
        logic uplink;
        bprx_mod_type modulation;
    } bprx_sched_type;

    typedef struct packed {
        logic [7:0] data;
        logic [3:0] layer;
        logic [7:0] symbol;
        bprx_mod_type modulation;
    } bprx_byte_type;

endpackage

// ### core/bprx_front_end.sv
// Receive front end: router, throttle, reordering, demapper and packer.
//
// Function
// [R1] No back-pressure downstream; a throttle paces blocks for all later stages.
// [R2] Take each resource_block from one of up to four processors, round robin.
// [R3] Routed words go to a local queue holding at least one resource_block.
// [R4] Start reading only when the queue holds a whole resource_block.
// [R5] Next resource_block starts no sooner than 144 cycles after the last.
// [R6] After a symbol's last resource_block, idle 120 cycles.
// [R7] Store 12-layer blocks in a two-page memory; fill one, read other.
// [R8] A counter detects a full page and triggers its read-out.
// [R9] Read out a whole symbol of layer 1, then layer 2, and onward.
// [R10] Once per frame copy the software-selected symbol to the host queue.
// [R11] Copy only if the host queue has room for a whole symbol.
// [R12] Demap each sample to eight hard bits as 256-QAM, one byte out.
// [R13] Bit labels use Gray coding as in the 802.11a mapping.
// [R14] Soft values from decision boundaries; their sign picks each bit.
// [R15] Schedule parser gives layer, symbol and modulation for every byte.
// [R16] Skip uplink symbols in downlink mode, and the reverse.
// [R17] Optionally keep one selected layer, or only layers with modulation.
// [R18] Parsing starts once software has written the schedule memory.
// [R19] Keep only the bits the modulation uses and regroup them into bytes.
// [R20] Each transport block's payload starts on a byte boundary.
// [R21] Layers with no modulation are dropped by holding valid low.
// [R22] Sustain one payload byte per clock cycle.
// [R23] Upstream sends 2.14 samples, two per sixty_four_bit_word.
// [R24] Reset selects page zero, clears counters and timer, valids low.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module bprx_front_end #(
    parameter int RB_PER_SYM = 100,
    parameter int FIFO_DEPTH = 128
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // Upstream processor links
    input wire logic [bprx_pkg::MAX_PROC-1:0] LINK_VALID,
    input wire logic [bprx_pkg::MAX_PROC-1:0][63:0] LINK_DATA,
    output logic [bprx_pkg::MAX_PROC-1:0] LINK_READY,
    // Target to host queue
    input wire logic [15:0] HOSTQ_FREE,
    output logic HOSTQ_VALID,
    output bprx_pkg::bprx_iq_type HOSTQ_DATA,
    // Packed byte stream
    output logic BYTE_VALID,
    output bprx_pkg::bprx_byte_type BYTE_OUT
);
    import bprx_pkg::*;

    localparam int SYM_LEN = RB_PER_SYM * SC_PER_RB;
    localparam int PAGE = NUM_LAYERS * SYM_LEN;
    localparam int AW = $clog2(2 * PAGE);
    localparam int IW = $clog2(SYM_LEN);
    localparam int FW = $clog2(FIFO_DEPTH);

    typedef enum logic [0:0] {TH_WAIT, TH_READ} bprx_th_type;

    function automatic logic [AW-1:0] rdm_addr(input logic page,
            input logic [3:0] layer, input logic [IW-1:0] idx);
        rdm_addr = AW'(page ? PAGE : 0) + AW'(int'(layer) * SYM_LEN)
            + AW'(idx);
    endfunction

    function automatic logic [3:0] axis_bits(input logic signed [15:0] x);
        logic signed [17:0] a;
        logic signed [17:0] d1;
        logic signed [17:0] d2;
        a = (x < 0) ? -18'(x) : 18'(x);
        d1 = (a >= QAM_B1) ? a - QAM_B1 : QAM_B1 - a;
        d2 = (d1 >= QAM_B2) ? d1 - QAM_B2 : QAM_B2 - d1;
        axis_bits = {x >= 0, QAM_B1 - a >= 0, QAM_B2 - d1 >= 0,
            QAM_B3 - d2 >= 0};
    endfunction

    function automatic logic [11:0] pick_bits(input logic [7:0] b,
            input bprx_mod_type m);
        case (m)
            MOD_BPSK: pick_bits = {4'h1, b[7], 7'h00};
            MOD_QPSK: pick_bits = {4'h2, b[7], b[3], 6'h00};
            MOD_QAM16: pick_bits = {4'h4, b[7:6], b[3:2], 4'h0};
            MOD_QAM64: pick_bits = {4'h6, b[7:5], b[3:1], 2'h0};
            MOD_QAM256: pick_bits = {4'h8, b};
            default: pick_bits = 12'h000;
        endcase
    endfunction

    logic [31:0] ctrl;
    logic [7:0] host_sym;
    logic sched_ready;
    logic host_drop;
    bprx_sched_type sched_mem [4096];
    logic [1:0] src;
    logic [6:0] rt_cnt;
    logic [1:0] next_src;
    logic [6:0] next_rt_cnt;
    logic accept;
    logic [63:0] fifo_mem [FIFO_DEPTH];
    logic [FW-1:0] wp;
    logic [FW-1:0] rp;
    logic [FW:0] fifo_count;
    bprx_th_type th_state;
    logic [7:0] th_cnt;
    logic [6:0] th_words;
    logic [6:0] th_rb;
    logic th_phase;
    logic th_pop;
    logic th_start;
    logic th_sym_end;
    logic [63:0] th_hold;
    logic s_valid;
    bprx_iq_type s_data;
    bprx_iq_type rdm [2 * PAGE];
    logic wr_page;
    logic [3:0] wr_layer;
    logic [3:0] wr_sc;
    logic [6:0] wr_rb;
    logic wr_last;
    logic rd_active;
    logic rd_page;
    logic [3:0] rd_layer;
    logic [IW-1:0] rd_idx;
    logic [7:0] rd_sym;
    logic [7:0] sym_cnt;
    logic host_en;
    logic rd_v1;
    bprx_iq_type rd_data;
    logic [3:0] t1_layer;
    logic [7:0] t1_sym;
    logic dm_valid;
    logic [7:0] dm_byte;
    logic [3:0] dm_layer;
    logic [7:0] dm_sym;
    bprx_sched_type ent;
    logic take;
    logic emit;
    logic [15:0] acc;
    logic [3:0] acc_n;
    logic [11:0] pk_tag;
    logic [11:0] pv;
    logic [15:0] next_acc;
    logic [3:0] next_n;
    logic [7:0] next_byte;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl <= CTRL_RESET;
            host_sym <= HOST_SYM_RESET;
            sched_ready <= 1'b0;
        end else if (REG_WR) begin
            if (REG_ADDR == REG_CTRL) ctrl <= REG_WDATA;
            if (REG_ADDR == REG_HOST_SYM) host_sym <= REG_WDATA[7:0];
            if (REG_ADDR == REG_SCHED) sched_ready <= 1'b1; // [R18]
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (REG_WR && REG_ADDR == REG_SCHED) begin
            sched_mem[{REG_WDATA[SCHED_SYM +: 8],
                REG_WDATA[SCHED_LAYER +: 4]}] <=
                bprx_sched_type'(REG_WDATA[SCHED_ENTRY +: 4]);
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            REG_RDATA <= 32'h0000_0000;
        end else if (REG_RD) begin
            case (REG_ADDR)
                REG_CTRL: REG_RDATA <= ctrl;
                REG_HOST_SYM: REG_RDATA <= {24'h000000, host_sym};
                REG_STATUS: REG_RDATA <= {16'h0000, sym_cnt, 4'h0,
                    host_drop, host_en, wr_page, sched_ready};
                default: REG_RDATA <= 32'h0000_0000;
            endcase
        end else begin
            REG_RDATA <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ready is registered, so it is computed from the source of next cycle.
    always_comb begin
        accept = LINK_VALID[src] & LINK_READY[src];
        next_src = src;
        next_rt_cnt = rt_cnt;
        if (accept) begin
            if (rt_cnt == 7'(RB_WORDS - 1)) begin
                next_rt_cnt = 7'h00;
                next_src = (src == ctrl[CTRL_NPROC +: 2]) ? 2'h0
                    : src + 2'h1; // [R2]
            end else begin
                next_rt_cnt = rt_cnt + 7'h01;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            src <= 2'h0;
            rt_cnt <= 7'h00;
            LINK_READY <= 4'h0;
        end else begin
            src <= next_src;
            rt_cnt <= next_rt_cnt;
            LINK_READY <= (fifo_count < (FW+1)'(FIFO_DEPTH - 2))
                ? 4'h1 << next_src : 4'h0; // [R2] [R3]
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (accept) fifo_mem[wp] <= LINK_DATA[src]; // [R3]
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wp <= '0;
            rp <= '0;
            fifo_count <= '0;
        end else begin
            wp <= wp + FW'(accept);
            rp <= rp + FW'(th_pop);
            fifo_count <= fifo_count + (FW+1)'(accept)
                - (FW+1)'(th_pop);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pacing replaces handshakes further down the path.
    assign th_start = th_state == TH_WAIT && th_cnt == 8'h00
        && fifo_count >= (FW+1)'(RB_WORDS); // [R1] [R4]
    assign th_pop = th_state == TH_READ && !th_phase;
    assign th_sym_end = th_state == TH_READ && th_phase
        && th_words == 7'(RB_WORDS - 1) && th_rb == 7'(RB_PER_SYM - 1);

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            th_state <= TH_WAIT;
            th_cnt <= 8'h00;
            th_words <= 7'h00;
            th_rb <= 7'h00;
            th_phase <= 1'b0; // [R24]
        end else begin
            case (th_state)
                TH_WAIT: begin
                    if (th_cnt != 8'h00) begin
                        th_cnt <= th_cnt - 8'h01;
                    end else if (th_start) begin
                        th_state <= TH_READ;
                        th_cnt <= 8'(RB_SPACING - 1); // [R5]
                        th_words <= 7'h00;
                        th_phase <= 1'b0;
                    end
                end
                TH_READ: begin
                    th_phase <= !th_phase;
                    if (th_cnt != 8'h00) th_cnt <= th_cnt - 8'h01;
                    if (th_phase && th_words == 7'(RB_WORDS - 1)) begin
                        th_state <= TH_WAIT;
                        if (th_sym_end) begin
                            th_rb <= 7'h00;
                            th_cnt <= 8'(SYMBOL_GAP); // [R6]
                        end else begin
                            th_rb <= th_rb + 7'h01;
                        end
                    end else if (th_phase) begin
                        th_words <= th_words + 7'h01;
                    end
                end
                default: th_state <= TH_WAIT;
            endcase
        end
    end

    // Each word carries two samples, upper half first.
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_valid <= 1'b0;
            s_data <= '0;
            th_hold <= 64'h0;
        end else begin
            s_valid <= th_state == TH_READ;
            if (th_pop) th_hold <= fifo_mem[rp];
            s_data <= th_pop ? fifo_mem[rp][63:32]
                : th_hold[31:0]; // [R23]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign wr_last = s_valid && wr_layer == 4'(NUM_LAYERS - 1)
        && wr_sc == 4'(SC_PER_RB - 1) && wr_rb == 7'(RB_PER_SYM - 1);

    always_ff @(posedge SYS_CLK) begin
        if (s_valid) begin
            rdm[rdm_addr(wr_page, wr_layer,
                IW'(int'(wr_rb) * SC_PER_RB + int'(wr_sc)))] <= s_data;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_page <= 1'b0;
            wr_layer <= 4'h0;
            wr_sc <= 4'h0;
            wr_rb <= 7'h00; // [R24]
        end else if (s_valid) begin
            wr_layer <= wr_layer + 4'h1;
            if (wr_layer == 4'(NUM_LAYERS - 1)) begin
                wr_layer <= 4'h0;
                wr_sc <= wr_sc + 4'h1;
                if (wr_sc == 4'(SC_PER_RB - 1)) begin
                    wr_sc <= 4'h0;
                    wr_rb <= wr_rb + 7'h01;
                    if (wr_last) begin
                        wr_rb <= 7'h00;
                        wr_page <= !wr_page; // [R7] [R8]
                    end
                end
            end
        end
    end

    // The page just filled is read while the other one fills.
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rd_active <= 1'b0;
            rd_page <= 1'b0;
            rd_layer <= 4'h0;
            rd_idx <= '0;
            rd_sym <= 8'h00;
            sym_cnt <= 8'h00;
            host_en <= 1'b0;
            host_drop <= 1'b0;
        end else if (wr_last) begin
            rd_active <= 1'b1; // [R8]
            rd_page <= wr_page;
            rd_layer <= 4'h0;
            rd_idx <= '0;
            rd_sym <= sym_cnt;
            sym_cnt <= (sym_cnt == 8'(SYMBOLS_PER_FRAME - 1)) ? 8'h00
                : sym_cnt + 8'h01;
            host_en <= sym_cnt == host_sym
                && HOSTQ_FREE >= 16'(PAGE); // [R10] [R11]
            if (sym_cnt == host_sym) begin
                host_drop <= HOSTQ_FREE < 16'(PAGE);
            end
        end else if (rd_active) begin
            rd_idx <= rd_idx + IW'(1);
            if (rd_idx == IW'(SYM_LEN - 1)) begin
                rd_idx <= '0;
                rd_layer <= rd_layer + 4'h1; // [R9]
                if (rd_layer == 4'(NUM_LAYERS - 1)) rd_active <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        rd_data <= rdm[rdm_addr(rd_page, rd_layer, rd_idx)];
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rd_v1 <= 1'b0;
            t1_layer <= 4'h0;
            t1_sym <= 8'h00;
            dm_valid <= 1'b0;
            dm_byte <= 8'h00;
            dm_layer <= 4'h0;
            dm_sym <= 8'h00;
            HOSTQ_VALID <= 1'b0;
            HOSTQ_DATA <= '0;
        end else begin
            rd_v1 <= rd_active;
            t1_layer <= rd_layer;
            t1_sym <= rd_sym;
            dm_valid <= rd_v1;
            dm_byte <= {axis_bits(rd_data.i),
                axis_bits(rd_data.q)}; // [R12] [R13] [R14]
            dm_layer <= t1_layer;
            dm_sym <= t1_sym;
            HOSTQ_VALID <= rd_v1 && host_en; // [R10]
            HOSTQ_DATA <= rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bits per symbol are a multiple of eight, so a block never leaves a
    // partial byte; the restart below only guards against bad schedules.
    always_comb begin
        ent = sched_mem[{dm_sym, dm_layer}]; // [R15]
        take = dm_valid && sched_ready // [R18]
            && ent.uplink == ctrl[CTRL_UPLINK] // [R16]
            && (!ctrl[CTRL_ONE_LAYER]
                || dm_layer == ctrl[CTRL_LAYER +: 4]) // [R17]
            && (!ctrl[CTRL_SKIP_NONE] || ent.modulation != MOD_NONE);
        pv = pick_bits(dm_byte, ent.modulation); // [R19]
        if ({dm_sym, dm_layer} != pk_tag) begin
            next_acc = 16'(pv[7:0] >> (4'h8 - pv[11:8])); // [R20]
            next_n = pv[11:8];
        end else begin
            next_acc = (acc << pv[11:8])
                | 16'(pv[7:0] >> (4'h8 - pv[11:8]));
            next_n = acc_n + pv[11:8];
        end
        emit = take && ent.modulation != MOD_NONE
            && next_n >= 4'h8; // [R21]
        next_byte = 8'(next_acc >> (next_n - 4'h8));
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            acc <= 16'h0000;
            acc_n <= 4'h0;
            pk_tag <= 12'h000;
            BYTE_VALID <= 1'b0;
            BYTE_OUT <= '0;
        end else begin
            BYTE_VALID <= emit; // [R22]
            if (take) begin
                acc <= next_acc;
                acc_n <= emit ? next_n - 4'h8 : next_n;
                pk_tag <= {dm_sym, dm_layer};
            end
            if (emit) begin
                BYTE_OUT <= '{next_byte, dm_layer, dm_sym,
                    ent.modulation}; // [R19]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] since_start;
    logic [7:0] since_end;

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            since_start <= 8'hFF;
            since_end <= 8'hFF;
        end else begin
            since_start <= th_start ? 8'h00 : since_start
                + 8'(since_start != 8'hFF);
            since_end <= th_sym_end ? 8'h00 : since_end
                + 8'(since_end != 8'hFF);
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);

    start_full_a: assert property ($rose(th_state == TH_READ) |-> // [R4]
        $past(fifo_count) >= (FW+1)'(RB_WORDS))
        else $error("Block read began without a full block queued.");
    rb_spacing_a: assert property (th_start |-> // [R5]
        since_start >= 8'(RB_SPACING - 1))
        else $error("Blocks started closer than the reorder time.");
    symbol_gap_a: assert property (th_start && th_rb == 7'h00 |-> // [R6]
        since_end >= 8'(SYMBOL_GAP))
        else $error("Symbol gap shorter than required.");
    fifo_room_a: assert property (accept |-> // [R3]
        fifo_count < (FW+1)'(FIFO_DEPTH))
        else $error("Local queue overflow.");
    one_source_a: assert property ($onehot0(LINK_READY)) // [R2]
        else $error("More than one link ready at once.");
    page_swap_a: assert property (wr_last |=> // [R7]
        rd_active && rd_page != wr_page && rd_idx == '0)
        else $error("Read-out did not start on the filled page.");
    layer_order_a: assert property (rd_active && !wr_last && // [R9]
        rd_idx == IW'(SYM_LEN - 1) && rd_layer != 4'(NUM_LAYERS - 1)
        |=> rd_layer == $past(rd_layer) + 4'h1 && rd_idx == '0)
        else $error("Layer order broken in read-out.");
    host_room_a: assert property ($rose(host_en) |-> // [R11]
        $past(HOSTQ_FREE) >= 16'(PAGE)
        && $past(sym_cnt) == $past(host_sym))
        else $error("Host copy started without room.");
    demap_sign_a: assert property (rd_v1 |=> // [R14]
        dm_byte[7] == ($past(rd_data.i) >= 0)
        && dm_byte[3] == ($past(rd_data.q) >= 0))
        else $error("Sign bit does not follow the sample.");
    none_drop_a: assert property (BYTE_VALID |-> // [R21]
        BYTE_OUT.modulation != MOD_NONE)
        else $error("Byte emitted for a layer with no modulation.");
    reset_page_a: assert property ($rose(RESET_N) |-> // [R24]
        !wr_page && !BYTE_VALID && !HOSTQ_VALID)
        else $error("Reset state wrong.");

endmodule
`default_nettype wire

// ### testbench/bprx_up_model.sv
// Upstream processor model that feeds sample words over the links.
`timescale 1ns/1ps
`default_nettype none
module bprx_up_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic en,
    input wire logic slow,
    // Links
    input wire logic [3:0] ready,
    output logic [3:0] valid,
    output logic [3:0][63:0] data,
    output logic [31:0] words
);
    logic gap;
    logic [31:0] n;
    logic [63:0] word;
    ////////////////////////////////////////////////////////////////////
    // One shared count works because only one link is taken at a time.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            words <= '0;
            gap <= 1'b0;
        end else begin
            gap <= slow && (|(valid & ready));
            if (|(valid & ready)) begin
                words <= words + 32'h1;
            end
        end
    end
    // Two samples a word, upper first; all links show the same word, inverted while valid is low.
    assign n = words * 32'h2;
    assign word = {n[15:0], ~n[15:0], n[15:0] + 16'h1,
        ~(n[15:0] + 16'h1)};
    assign valid = {4{en & ~gap}};
    assign data = {4{valid[0] ? word : ~word}};
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the receive front end.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin \
    total_checks++; \
    if ((a) !== (e)) begin \
        err_total++; \
        $display("BAD %0t %s", $time, m); \
    end \
end
module tb_top;
    import bprx_pkg::*;
    localparam int RBS = 2;
    localparam int SYM_SAMP = NUM_LAYERS * RBS * SC_PER_RB;
    logic SYS_CLK = 1'b0;
    logic RESET_N, REG_WR, REG_RD, en = 1'b0, slow = 1'b1;
    logic [7:0] REG_ADDR;
    logic [31:0] REG_WDATA, REG_RDATA, words;
    logic [3:0] LINK_VALID, LINK_READY;
    logic [3:0][63:0] LINK_DATA;
    logic [15:0] HOSTQ_FREE;
    logic HOSTQ_VALID, BYTE_VALID;
    bprx_iq_type HOSTQ_DATA;
    bprx_byte_type BYTE_OUT;
    int err_total = 0, total_checks = 0, hcnt = 0;
    int bcnt [8] = '{default: 0};
    always #2.5 SYS_CLK = ~SYS_CLK;
    bprx_front_end #(.RB_PER_SYM(RBS), .FIFO_DEPTH(128)) u_dut (
        .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .LINK_VALID(LINK_VALID),
        .LINK_DATA(LINK_DATA), .LINK_READY(LINK_READY),
        .HOSTQ_FREE(HOSTQ_FREE), .HOSTQ_VALID(HOSTQ_VALID),
        .HOSTQ_DATA(HOSTQ_DATA), .BYTE_VALID(BYTE_VALID),
        .BYTE_OUT(BYTE_OUT));
    bprx_up_model u_model (.clk(SYS_CLK), .rst_n(RESET_N), .en(en),
        .slow(slow), .ready(LINK_READY), .valid(LINK_VALID),
        .data(LINK_DATA), .words(words));
    ////////////////////////////////////////////////////////////////////
    // Host copy runs layer-major; the links filled the page layer-minor.
    function automatic logic [31:0] samp(input int h);
        int n;
        n = SYM_SAMP + (h % (RBS * SC_PER_RB)) * NUM_LAYERS
            + h / (RBS * SC_PER_RB);
        return {n[15:0], ~n[15:0]};
    endfunction
    // Small positive I and negative Q sit on the innermost Gray labels.
    function automatic logic [7:0] bval(input bprx_byte_type b);
        return (b.symbol == 8'h01 && b.layer == 4'h2) ? 8'hAA : 8'hC4;
    endfunction
    task automatic finish_test;
        if (err_total == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge SYS_CLK);
        REG_WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] k,
                      input logic [31:0] e, input string m);
        @(posedge SYS_CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge SYS_CLK);
        REG_RD <= 1'b0;
        #1 `CHK(REG_RDATA & k, e, m)
    endtask
    ////////////////////////////////////////////////////////////////////
    // Monitors sample the values that stood just before each edge.
    always @(posedge SYS_CLK) begin
        if (RESET_N === 1'b1) begin
            `CHK($onehot0(LINK_READY), 1'b1, "ready")
            if (|(LINK_VALID & LINK_READY)) begin
                `CHK(LINK_READY, 4'h1 << ((words / 72) % 4), "route")
            end
            if (HOSTQ_VALID === 1'b1) begin
                `CHK(HOSTQ_DATA, samp(hcnt), "host")
                hcnt++;
            end
            if (BYTE_VALID === 1'b1 && BYTE_OUT.layer < 4'h4
                && BYTE_OUT.symbol[7:2] === 6'h00
                && BYTE_OUT.symbol[0] === 1'b1) begin
                `CHK(BYTE_OUT.data, bval(BYTE_OUT), "byte data")
                bcnt[{BYTE_OUT.symbol[1], BYTE_OUT.layer[1:0]}]++;
            end
        end
    end
    initial begin
        #100000;
        err_total++;
        finish_test;
    end
    initial begin
        RESET_N = 1'b0;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_ADDR = 8'h00;
        REG_WDATA = 32'h0;
        HOSTQ_FREE = 16'h0120;
        repeat (5) @(posedge SYS_CLK);
        RESET_N <= 1'b1;
        rd(REG_CTRL, '1, CTRL_RESET, "ctrl reset");
        rd(REG_HOST_SYM, 32'hFF, {24'h0, HOST_SYM_RESET}, "sym reset");
        rd(REG_STATUS, 32'h7, 32'h0, "status reset");
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10, '1, 32'h0, "unmapped");
        rd(REG_CTRL, '1, CTRL_RESET, "ignored");
        wr(REG_CTRL, 32'h3);
        rd(REG_CTRL, 32'h1F, 32'h3, "ctrl");
        wr(REG_HOST_SYM, 32'h1);
        wr(REG_SCHED, 32'h0001_0005);
        wr(REG_SCHED, 32'h0001_010A);
        wr(REG_SCHED, 32'h0001_0202);
        wr(REG_SCHED, 32'h0001_0300);
        wr(REG_SCHED, 32'h0003_0005);
        wr(REG_SCHED, 32'h0003_0205);
        rd(REG_STATUS, 32'h1, 32'h1, "sched ready");
        en <= 1'b1;
        for (int k = 0; k < 6000 && HOSTQ_VALID !== 1'b1; k++) begin
            @(posedge SYS_CLK);
        end
        // One entry short of a whole symbol, so the next copy must drop.
        slow <= 1'b0;
        HOSTQ_FREE <= 16'h011F;
        wr(REG_HOST_SYM, 32'h2);
        // Switch to one-layer mode once symbol 1 has left the pipeline.
        for (int k = 0; k < 600 && hcnt < SYM_SAMP; k++) begin
            @(posedge SYS_CLK);
        end
        repeat (10) @(posedge SYS_CLK);
        wr(REG_CTRL, 32'h0000_021B);
        for (int k = 0; k < 6000 && words < 720; k++) begin
            @(posedge SYS_CLK);
        end
        `CHK(words >= 720, 1'b1, "link stall")
        repeat (600) @(posedge SYS_CLK);
        `CHK(hcnt, SYM_SAMP, "host count")
        rd(REG_STATUS, 32'h8, 32'h8, "dropped");
        `CHK(bcnt[0], 24, "qam256 bytes")
        `CHK(bcnt[1], 0, "uplink skip")
        `CHK(bcnt[2], 6, "qpsk pack")
        `CHK(bcnt[3], 0, "none drop")
        `CHK(bcnt[4], 0, "one layer")
        `CHK(bcnt[6], 24, "kept layer")
        finish_test;
    end
endmodule
`default_nettype wire
